// File: bench/dcdc_clock_config_tb_top.sv
// self-checking bench for the converter clock configuration block
`timescale 1ns/1ps
`default_nettype none
module dcdc_clock_config_tb_top;
    import dcdcc_pkg::*;

    logic        clk, rst, wr, rd, lo, en, slp, sus;
    dcdcc_byte_t addr, wdata, rdata;
    logic        conv, sar, trk, peak, tobat, flt, creg, bias;
    logic        rd_seen, conv_smp, lo_smp, ph0;
    logic        par = 1'b0;
    int          mismatches, tests_run, seed, i, rnd_lo, rnd_cfg;
    dcdcc_byte_t exp_q[$];

    dcdcc_top u_dut (
        .CORE_CLK      (clk),
        .RESET         (rst),
        .SFR_ADDR      (addr),
        .SFR_WR        (wr),
        .SFR_RD        (rd),
        .SFR_WDATA     (wdata),
        .SFR_RDATA     (rdata),
        .LOCAL_OSC     (lo),
        .DCDC_EN       (en),
        .SLEEP         (slp),
        .SUSPEND       (sus),
        .CONV_CLK      (conv),
        .SAR_CLK       (sar),
        .ADC_TRACK     (trk),
        .PEAK_CUR_HIGH (peak),
        .SUPPLY_TO_BAT (tobat),
        .SUPPLY_FLOAT  (flt),
        .CORE_REG_EN   (creg),
        .OSC_BIAS_EN   (bias)
    );

    // ============================================================
    // clock, helpers
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        tests_run++;
        if (got !== want) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic sfr_wr(input dcdcc_byte_t a, input dcdcc_byte_t d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic sfr_rd(input dcdcc_byte_t a, input dcdcc_byte_t want);
        exp_q.push_back(want);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    // ============================================================
    // output watcher: read answers come off the note queue
    always @(posedge clk) begin
        rnd_lo    = $random(seed);
        rd_seen  <= rd;
        conv_smp <= conv;
        lo_smp   <= lo;
        lo       <= rnd_lo[0];
        par      <= ~par;
    end

    always @(negedge clk) begin
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(8'h01, 8'h00);
            end else begin
                chk(rdata, exp_q.pop_front());
            end
        end
    end

    // ============================================================
    // converter clock measurements
    task automatic half(input logic [7:0] want);
        int k, n;
        k = 0;
        n = 0;
        while (conv !== 1'b0 && k < 64) begin
            @(negedge clk);
            k++;
        end
        while (conv !== 1'b1 && k < 64) begin
            @(negedge clk);
            k++;
        end
        while (conv === 1'b1 && k < 64) begin
            @(negedge clk);
            n++;
            k++;
        end
        if (k >= 64) begin
            mismatches++;
            report_and_stop();
        end
        chk(n[7:0], want);
        @(posedge clk);
    endtask

    task automatic sar_run(input logic sync, input logic pol);
        sfr_wr(ADDR_CONV_CTL, 8'h21 | {4'h0, sync, 3'h0});
        sfr_wr(ADDR_CLK_CFG, 8'h41 | {3'h0, pol, 4'h0});
        repeat (40) @(posedge clk);
        for (int j = 0; j < 16; j++) begin
            @(negedge clk);
            chk({6'h0, sar, trk}, {6'h0, sync & (pol ? conv_smp : ~conv_smp),
                                   sync & ~conv_smp});
        end
        @(posedge clk);
    endtask

    // ============================================================
    // main sequence
    initial begin
        seed = 96;
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        en = 1'b0;
        slp = 1'b0;
        sus = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        mismatches = 0;
        tests_run = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        sfr_rd(ADDR_CLK_CFG, 8'h00);
        sfr_rd(ADDR_CONV_CTL, 8'h21);
        sfr_rd(ADDR_REG_CTL, 8'h10);
        sfr_rd(8'h55, 8'h00);
        sfr_wr(8'h55, 8'hff);
        sfr_wr(ADDR_CLK_CFG, 8'h7f);
        sfr_rd(ADDR_CLK_CFG, 8'h7f);
        for (i = 0; i < 8; i++) begin
            rnd_cfg = $random(seed);
            sfr_wr(ADDR_CLK_CFG, rnd_cfg[7:0] & 8'h7f);
            sfr_rd(ADDR_CLK_CFG, rnd_cfg[7:0] & 8'h7f);
        end
        for (i = 0; i < 4; i++) begin
            sfr_wr(ADDR_CLK_CFG, {1'b0, i[1:0], 5'h01});
            repeat (40) @(posedge clk);
            half(8'h01 << i);
        end
        sfr_wr(ADDR_CLK_CFG, 8'h29);
        repeat (40) @(posedge clk);
        half(8'h02);
        // invert flips the undivided clock against the core cycle parity
        sfr_wr(ADDR_CLK_CFG, 8'h01);
        repeat (40) @(posedge clk);
        @(negedge clk);
        ph0 = conv ^ par;
        @(posedge clk);
        sfr_wr(ADDR_CLK_CFG, 8'h09);
        repeat (40) @(posedge clk);
        @(negedge clk);
        chk({7'h0, conv ^ par}, {7'h0, ~ph0});
        @(posedge clk);
        sfr_wr(ADDR_CLK_CFG, 8'h68);
        repeat (40) @(posedge clk);
        // divider change under the local source must not start a switch
        sfr_wr(ADDR_CLK_CFG, 8'h08);
        for (i = 0; i < 24; i++) begin
            @(negedge clk);
            chk({7'h0, conv}, {7'h0, lo_smp});
        end
        @(posedge clk);
        sar_run(1'b1, 1'b0);
        sar_run(1'b1, 1'b1);
        sar_run(1'b0, 1'b1);
        for (i = 0; i < 16; i++) begin
            en  <= i[3];
            slp <= i[2];
            sus <= i[1];
            sfr_wr(ADDR_CLK_CFG, {5'h00, i[0], i[0], 1'b1});
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk({4'h0, peak, tobat, flt, creg},
                {4'h0, i[0], i[3] & i[2] & ~i[0], i[3] & i[2] & i[0],
                 ~i[2]});
            @(posedge clk);
        end
        // oscillator bias is only dropped while the oscillator is unused
        sfr_wr(ADDR_REG_CTL, 8'h00);
        repeat (2) @(posedge clk);
        chk({7'h0, bias}, 8'h00);
        sfr_rd(ADDR_REG_CTL, 8'h00);
        sfr_wr(ADDR_REG_CTL, 8'hff);
        sfr_rd(ADDR_REG_CTL, 8'h10);
        chk({7'h0, bias}, 8'h01);
        repeat (4) @(posedge clk);
        report_and_stop();
    end
endmodule
`default_nettype wire

// File: rtl/dcdcc_div.sv
// system clock divider with input inversion for the converter clock
`timescale 1ns/1ps
`default_nettype none
module dcdcc_div
    import dcdcc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [1:0] code,
    input  wire logic       inv,
    output var  logic       conv_q
);
    // ============================================================
    // free running model of the system clock, one phase per cycle
    logic                  sys_q, sys_d;
    logic                  sel_d;
    logic [HALF_CNT_W-1:0] cnt_q, cnt_d;
    logic                  div_q, div_d;
    logic                  conv_d;

    always_comb begin
        sys_d  = ~sys_q;
        sel_d  = sys_d ^ inv;                           // [RQ4]
        cnt_d  = cnt_q;
        div_d  = div_q;
        conv_d = 1'b0;
        if (!run) begin
            cnt_d = '0;
            div_d = 1'b0;
        end else begin
            if (sel_d) begin
                if (cnt_q >= (half_cycles(code) >> 1) - 4'h1) begin // [RQ1]
                    cnt_d = '0;
                    div_d = ~div_q;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            conv_d = (code == DCDCC_DIV1) ? sel_d : div_d; // [RQ1]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sys_q  <= 1'b0;
            cnt_q  <= '0;
            div_q  <= 1'b0;
            conv_q <= 1'b0;
        end else begin
            sys_q  <= sys_d;
            cnt_q  <= cnt_d;
            div_q  <= div_d;
            conv_q <= conv_d;
        end
    end

    // ============================================================
    // checks
    default clocking dcb @(posedge clk); endclocking
    default disable iff (rst || !run);

    sequence s_div8_rise;
        $rose(conv_q) && code == DCDCC_DIV8;
    endsequence

    AST_DIV8_HIGH: assert property ( // [RQ1]
        s_div8_rise |-> conv_q [*8] ##1 !conv_q
    ) else $error("divide by eight high phase not eight cycles");

    AST_DIV2_HIGH: assert property ( // [RQ1]
        $rose(conv_q) && code == DCDCC_DIV2 |-> conv_q [*2] ##1 !conv_q
    ) else $error("divide by two high phase not two cycles");

    AST_DIV1_INV: assert property ( // [RQ4]
        $past(run) && code == DCDCC_DIV1 |-> conv_q == (sys_q ^ inv)
    ) else $error("undivided clock not following inverted system clock");

endmodule
`default_nettype wire

// File: rtl/dcdcc_pkg.sv
// constants and types for the converter clock configuration block
// ============================================================
// Notes on behaviour
// RQ1: system clock source is divided by 1, 2, 4 or 8 per divider code.
// RQ2: divider code is ignored while the local oscillator clocks the converter.
// RQ3: source bit 0 picks local oscillator, 1 picks system clock.
// RQ4: invert bit 1 inverts system clock ahead of the divider.
// RQ5: with sync on, polarity 0 inverts SAR clock, 1 passes it straight.
// RQ6: SAR polarity bit has no effect while sync is off.
// RQ7: peak current bit 0 selects low limit, 1 selects high limit.
// RQ8: converter on and asleep: bit 0 ties supply pin to battery, 1 floats.
// RQ9: config bit 7 reads zero; software writes zero there.
// RQ10: core regulator off in sleep, stays on in suspend.
// RQ11: a regulator control bit lets software switch off oscillator bias.
// RQ12: software turns oscillator bias off only when oscillator unused.
// RQ13: sync bit 3 puts ADC tracking in quiet interval, SAR clock locked.
// RQ14: source, divider and invert changes never glitch the converter clock; ST_DRAIN forces it low at once, even inside a divided high phase.
package dcdcc_pkg;

    typedef logic [7:0] dcdcc_byte_t;

    typedef enum logic [1:0] {
        DCDCC_DIV1,
        DCDCC_DIV2,
        DCDCC_DIV4,
        DCDCC_DIV8
    } dcdcc_div_e;

    // ============================================================
    // register addresses
    localparam dcdcc_byte_t ADDR_CLK_CFG  = 8'h96;
    localparam dcdcc_byte_t ADDR_CONV_CTL = 8'h97;
    localparam dcdcc_byte_t ADDR_REG_CTL  = 8'hc9;

    // ============================================================
    // reset values and writable masks
    localparam dcdcc_byte_t CLK_CFG_RST   = 8'h00;
    localparam dcdcc_byte_t CLK_CFG_WMASK = 8'h7f;
    localparam dcdcc_byte_t CONV_CTL_RST  = 8'h21;
    localparam dcdcc_byte_t CONV_CTL_WMASK = 8'hef;
    localparam dcdcc_byte_t REG_CTL_RST   = 8'h10;
    localparam dcdcc_byte_t REG_CTL_WMASK = 8'h10;

    // ============================================================
    // field positions
    localparam int CFG_SRC_BIT    = 0;
    localparam int CFG_SLEEP_BIT  = 1;
    localparam int CFG_PEAK_BIT   = 2;
    localparam int CFG_INV_BIT    = 3;
    localparam int CFG_SARPOL_BIT = 4;
    localparam int CFG_DIV_LSB    = 5;
    localparam int CFG_DIV_MSB    = 6;
    localparam int CFG_RSV_BIT    = 7;
    localparam int CTL_SYNC_BIT   = 3;
    localparam int REG_BIAS_BIT   = 4;

    localparam logic SRC_LOCAL = 1'b0;
    localparam logic SRC_SYS   = 1'b1;

    localparam int HALF_CNT_W = 4;

    // converter clock half period, in core cycles, for a divider code
    function automatic logic [HALF_CNT_W-1:0] half_cycles(
        input logic [1:0] code
    );
        half_cycles = 4'h1 << code;
    endfunction

endpackage

// File: rtl/dcdcc_sar.sv
// SAR clock polarity and ADC tracking window while synchronised
`timescale 1ns/1ps
`default_nettype none
module dcdcc_sar
    import dcdcc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic conv,
    input  wire logic sync,
    input  wire logic pol,
    output var  logic sar_q,
    output var  logic track_q
);
    logic sar_d, track_d;

    always_comb begin
        sar_d   = 1'b0;                                 // [RQ6]
        track_d = 1'b0;
        if (sync) begin
            sar_d   = pol ? conv : ~conv;               // [RQ5] [RQ13]
            track_d = ~conv;                            // [RQ13]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sar_q   <= 1'b0;
            track_q <= 1'b0;
        end else begin
            sar_q   <= sar_d;
            track_q <= track_d;
        end
    end

    // ============================================================
    // checks
    default clocking scb @(posedge clk); endclocking
    default disable iff (rst);

    AST_SAR_POL: assert property ( // [RQ5]
        sync |=> sar_q == ($past(pol) ? $past(conv) : !$past(conv))
    ) else $error("SAR clock polarity wrong while synchronised");

    AST_SAR_IGNORED: assert property ( // [RQ6]
        !sync |=> !sar_q && !track_q
    ) else $error("SAR clock active while sync is off");

endmodule
`default_nettype wire

// File: rtl/dcdcc_top.sv
// converter clock configuration registers, clock switch and power controls
`timescale 1ns/1ps
`default_nettype none
module dcdcc_top
    import dcdcc_pkg::*;
(
    input  wire logic               CORE_CLK,
    input  wire logic               RESET,
    input  wire dcdcc_pkg::dcdcc_byte_t SFR_ADDR,
    input  wire logic               SFR_WR,
    input  wire logic               SFR_RD,
    input  wire dcdcc_pkg::dcdcc_byte_t SFR_WDATA,
    output var  dcdcc_pkg::dcdcc_byte_t SFR_RDATA,
    input  wire logic               LOCAL_OSC,
    input  wire logic               DCDC_EN,
    input  wire logic               SLEEP,
    input  wire logic               SUSPEND,
    output var  logic               CONV_CLK,
    output var  logic               SAR_CLK,
    output var  logic               ADC_TRACK,
    output var  logic               PEAK_CUR_HIGH,
    output var  logic               SUPPLY_TO_BAT,
    output var  logic               SUPPLY_FLOAT,
    output var  logic               CORE_REG_EN,
    output var  logic               OSC_BIAS_EN
);
    // ============================================================
    // register file
    dcdcc_byte_t cfg_q, cfg_d;
    dcdcc_byte_t ctl_q, ctl_d;
    dcdcc_byte_t reg_q, reg_d;
    dcdcc_byte_t rdata_d;

    function automatic dcdcc_byte_t wmerge(
        input dcdcc_byte_t old,
        input dcdcc_byte_t wdata,
        input dcdcc_byte_t mask
    );
        wmerge = (old & ~mask) | (wdata & mask);
    endfunction

    always_comb begin
        cfg_d = cfg_q;
        ctl_d = ctl_q;
        reg_d = reg_q;
        if (SFR_WR) begin
            unique case (SFR_ADDR)
                ADDR_CLK_CFG: begin
                    // reserved top bit is never stored
                    cfg_d = wmerge(cfg_q, SFR_WDATA, CLK_CFG_WMASK); // [RQ9]
                end
                ADDR_CONV_CTL: begin
                    ctl_d = wmerge(ctl_q, SFR_WDATA, CONV_CTL_WMASK);
                end
                ADDR_REG_CTL: begin
                    reg_d = wmerge(reg_q, SFR_WDATA, REG_CTL_WMASK); // [RQ11]
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (SFR_RD) begin
            unique case (SFR_ADDR)
                ADDR_CLK_CFG:  rdata_d = cfg_q & CLK_CFG_WMASK; // [RQ9]
                ADDR_CONV_CTL: rdata_d = ctl_q;
                ADDR_REG_CTL:  rdata_d = reg_q & REG_CTL_WMASK;
                default:       rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            cfg_q     <= CLK_CFG_RST;
            ctl_q     <= CONV_CTL_RST;
            reg_q     <= REG_CTL_RST;
            SFR_RDATA <= 8'h00;
        end else begin
            cfg_q     <= cfg_d;
            ctl_q     <= ctl_d;
            reg_q     <= reg_d;
            SFR_RDATA <= rdata_d;
        end
    end

    // ============================================================
    // clock switch: settings move to the active copy only while parked low
    typedef enum logic [1:0] {
        ST_RUN,
        ST_DRAIN,
        ST_PARK
    } dcdcc_sw_e;

    dcdcc_sw_e  st_q, st_d;
    logic       src_q, src_d;
    logic [1:0] div_q, div_d;
    logic       inv_q, inv_d;
    logic       run_q, run_d;
    logic       conv_d;
    logic       div_clk;
    logic       want_src;
    logic [1:0] want_div;
    logic       want_inv;
    logic       differs;

    always_comb begin
        want_src = cfg_q[CFG_SRC_BIT];
        want_div = cfg_q[CFG_DIV_MSB:CFG_DIV_LSB];
        want_inv = cfg_q[CFG_INV_BIT];
        // divider and invert only matter with the system clock selected
        differs  = (want_src != src_q) ||
                   (want_src == SRC_SYS &&
                    (want_div != div_q || want_inv != inv_q)); // [RQ2]
    end

    always_comb begin
        st_d  = st_q;
        src_d = src_q;
        div_d = div_q;
        inv_d = inv_q;
        unique case (st_q)
            ST_RUN: begin
                if (differs) begin
                    st_d = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                // leave only once the present clock is already low
                if (!CONV_CLK) begin                    // [RQ14]
                    st_d  = ST_PARK;
                    src_d = want_src;
                    div_d = want_div;
                    inv_d = want_inv;
                end
            end
            ST_PARK: begin
                // local oscillator may be high; wait for its low phase
                if (src_q == SRC_SYS || !LOCAL_OSC) begin // [RQ14]
                    st_d = ST_RUN;
                end
            end
        endcase
        run_d = (st_d == ST_RUN) && (src_d == SRC_SYS);
    end

    always_comb begin
        conv_d = 1'b0;                                  // [RQ14]
        if (st_q == ST_RUN) begin
            if (src_q == SRC_SYS) begin                 // [RQ3]
                conv_d = div_clk;                       // [RQ1]
            end else begin
                conv_d = LOCAL_OSC;                     // [RQ2] [RQ3]
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            st_q     <= ST_RUN;
            src_q    <= SRC_LOCAL;
            div_q    <= DCDCC_DIV1;
            inv_q    <= 1'b0;
            run_q    <= 1'b0;
            CONV_CLK <= 1'b0;
        end else begin
            st_q     <= st_d;
            src_q    <= src_d;
            div_q    <= div_d;
            inv_q    <= inv_d;
            run_q    <= run_d;
            CONV_CLK <= conv_d;
        end
    end

    dcdcc_div u_div (
        .clk    (CORE_CLK),
        .rst    (RESET),
        .run    (run_q),
        .code   (div_q),
        .inv    (inv_q),
        .conv_q (div_clk)
    );

    dcdcc_sar u_sar (
        .clk     (CORE_CLK),
        .rst     (RESET),
        .conv    (CONV_CLK),
        .sync    (ctl_q[CTL_SYNC_BIT]),
        .pol     (cfg_q[CFG_SARPOL_BIT]),
        .sar_q   (SAR_CLK),
        .track_q (ADC_TRACK)
    );

    // ============================================================
    // power controls
    logic peak_d, bat_d, float_d, core_d, bias_d;

    always_comb begin
        peak_d  = cfg_q[CFG_PEAK_BIT];                  // [RQ7]
        bat_d   = DCDC_EN && SLEEP && !cfg_q[CFG_SLEEP_BIT]; // [RQ8]
        float_d = DCDC_EN && SLEEP && cfg_q[CFG_SLEEP_BIT];  // [RQ8]
        core_d  = !SLEEP;                               // [RQ10]
        bias_d  = reg_q[REG_BIAS_BIT];                  // [RQ11]
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            PEAK_CUR_HIGH <= 1'b0;
            SUPPLY_TO_BAT <= 1'b0;
            SUPPLY_FLOAT  <= 1'b0;
            CORE_REG_EN   <= 1'b1;
            OSC_BIAS_EN   <= 1'b1;
        end else begin
            PEAK_CUR_HIGH <= peak_d;
            SUPPLY_TO_BAT <= bat_d;
            SUPPLY_FLOAT  <= float_d;
            CORE_REG_EN   <= core_d;
            OSC_BIAS_EN   <= bias_d;
        end
    end

    // ============================================================
    // checks
    default clocking tcb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    sequence s_cfg_read;
        SFR_RD && SFR_ADDR == ADDR_CLK_CFG;
    endsequence

    sequence s_bias_off_write;
        SFR_WR && SFR_ADDR == ADDR_REG_CTL && !SFR_WDATA[REG_BIAS_BIT];
    endsequence

    sequence s_bias_on_write;
        SFR_WR && SFR_ADDR == ADDR_REG_CTL && SFR_WDATA[REG_BIAS_BIT];
    endsequence

    // a switch starts from the running state once a setting differs
    sequence s_switch_start;
        st_q == ST_RUN && differs;
    endsequence

    AST_RSV_READ_ZERO: assert property ( // [RQ9]
        s_cfg_read |=> !SFR_RDATA[CFG_RSV_BIT]
    ) else $error("reserved config bit read as one");

    AST_LOCAL_PASS: assert property ( // [RQ3]
        st_q == ST_RUN && src_q == SRC_LOCAL |=> CONV_CLK == $past(LOCAL_OSC)
    ) else $error("local oscillator not passed undivided");

    AST_PARK_LOW: assert property ( // [RQ14]
        st_q != ST_RUN |=> !CONV_CLK
    ) else $error("converter clock high while switching");

    AST_SYS_FOLLOW: assert property ( // [RQ1]
        st_q == ST_RUN && src_q == SRC_SYS |=> CONV_CLK == $past(div_clk)
    ) else $error("system clock path not routed to converter clock");

    AST_PEAK: assert property ( // [RQ7]
        1'b1 |=> PEAK_CUR_HIGH == $past(cfg_q[CFG_PEAK_BIT])
    ) else $error("peak current select not following config");

    AST_SLEEP_SUPPLY: assert property ( // [RQ8]
        DCDC_EN && SLEEP |=> (SUPPLY_FLOAT != SUPPLY_TO_BAT) &&
            SUPPLY_FLOAT == $past(cfg_q[CFG_SLEEP_BIT])
    ) else $error("sleep supply connection wrong");

    AST_REG_SLEEP: assert property ( // [RQ10]
        SLEEP |=> !CORE_REG_EN
    ) else $error("core regulator left on in sleep");

    AST_REG_SUSPEND: assert property ( // [RQ10]
        SUSPEND && !SLEEP |=> CORE_REG_EN
    ) else $error("core regulator switched off in suspend");

    AST_SUPPLY_AWAKE: assert property ( // [RQ8]
        !(DCDC_EN && SLEEP) |=> !SUPPLY_FLOAT && !SUPPLY_TO_BAT
    ) else $error("supply pin connection driven outside sleep");

    AST_BIAS_OFF: assert property ( // [RQ11]
        s_bias_off_write |=> ##1 !OSC_BIAS_EN
    ) else $error("oscillator bias not switched off");

    AST_BIAS_ON: assert property ( // [RQ11]
        s_bias_on_write |=> ##1 OSC_BIAS_EN
    ) else $error("oscillator bias not switched back on");

    AST_SWITCH_DRAIN: assert property ( // [RQ14]
        s_switch_start |=> st_q == ST_DRAIN
    ) else $error("setting change did not start a clock switch");

    AST_DRAIN_BOUND: assert property ( // [RQ14]
        st_q == ST_DRAIN |=> ##[0:1] st_q == ST_PARK
    ) else $error("clock switch stuck waiting for a low phase");

    AST_PARK_EXIT: assert property ( // [RQ14]
        st_q == ST_PARK && src_q == SRC_SYS |=> st_q == ST_RUN && !CONV_CLK
    ) else $error("system clock switch did not resume parked low");

    AST_LOCAL_NO_SWITCH: assert property ( // [RQ2]
        st_q == ST_RUN && src_q == SRC_LOCAL && want_src == SRC_LOCAL
            |=> st_q == ST_RUN
    ) else $error("divider change disturbed the local oscillator clock");

endmodule
`default_nettype wire
